// file: design/cmc_cfg.svh
// Constants of the message center controller: offsets, fields, resets, sizes
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define CMC_CENTERS 15
`define CMC_ID_W 29
`define CMC_WORDS_PER_CENTER 4
`define CMC_MEM_WORDS 60
`define CMC_FIFO_DEPTH 8
`define CMC_ADDR_W 8

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CMC_OFS_CTRL 8'h00
`define CMC_OFS_STATUS 8'h04
`define CMC_OFS_NEW_DATA 8'h08
`define CMC_OFS_BIT_TIMING 8'h0C
`define CMC_OFS_ID_MASK 8'h10
`define CMC_OFS_DATA_MASK 8'h14
`define CMC_OFS_ARB_BYTE0 8'h18
`define CMC_OFS_ARB_BYTE1 8'h1C
`define CMC_OFS_DP_POINTER 8'h20
`define CMC_OFS_DP_BUFFER 8'h24
`define CMC_OFS_CENTER_FIRST 8'h40
`define CMC_OFS_CENTER_LAST 8'h78

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CMC_CTRL_EN_BIT 0
`define CMC_CTRL_ARB_BIT 1
`define CMC_STAT_ERR_BIT 0
`define CMC_CC_RXNEW_BIT 16
`define CMC_IDW_IDE_BIT 31

// ------------------------------------------------------------
// Reset values, identifier format masks and bus answers
// ------------------------------------------------------------
`define CMC_RST_BIT_TIMING 32'h0000_0000
`define CMC_RST_ID_MASK 29'h0000_0000
`define CMC_RST_DATA_MASK 16'h0000
`define CMC_RST_ARB_BYTE 8'h00
`define CMC_STD_ID_MASK 29'h0000_07FF
`define CMC_EXT_ID_MASK 29'h1FFF_FFFF
`define CMC_RESP_OKAY 2'h0
`define CMC_RESP_DECERR 2'h3

`endif

// file: design/cmc_pkg.sv
// Types shared by the message center controller
`include "cmc_cfg.svh"
package cmc_pkg;

  typedef struct packed {
    logic ide;
    logic rtr;
    logic [`CMC_ID_W-1:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } cmc_frame_t;

  typedef struct packed {
    logic rx_new;
    logic [3:0] dlc;
    logic auto_reply;
    logic masked;
    logic int_en;
    logic transmit_request;
    logic center_ready;
    logic data_updated;
    logic transmit_inhibit;
    logic dir;
  } cmc_center_t;

  typedef enum logic [1:0] {
    cmc_s_idle = 2'b00,
    cmc_s_tx = 2'b01
  } cmc_state_t;

endpackage

// file: design/cmc_top.sv
// Message center controller with receive frame FIFO and AXI4-Lite registers
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cmc_cfg.svh"

// ------------------------------------------------------------
// Frame FIFO
// ------------------------------------------------------------
module cmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // DEPTH must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [0:DEPTH-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = buf_q[rp];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (push) buf_q[wp] <= in_data;
  end

  fifo_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cnt == (AW+1)'(DEPTH)) |-> !in_ready && out_valid)
    else $error("fifo full but still ready");
endmodule

// Behaviour
// - Fifteen centers, each an identifier plus up to eight data bytes.
// - Standard 11-bit and extended 29-bit identifiers, chosen per center.
// - Centers 1 to 14 are set by software to transmit or receive.
// - Center 15 only receives, taking frames no other center accepted.
// - A center accepts only frames whose identifier matches its own; center 15 here takes any identifier.
// - First two data bytes must also equal the two arbitration bytes.
// - Global mask bits drop out of comparisons for masked centers; remote-frame matching here ignores the mask.
// - Transmit needs direction 1, inhibit 0, updated, ready, request set.
// - A remote frame matching a transmit center gets its stored contents.
// - Identifiers, format and data sit in a dual-port memory.
// - Processor reaches that memory only via pointer and buffer registers.
// - Global and per-center control and status sit in register space.
// - Registers give errors, new data, timing, masks and source center.
// - Each center has direction, interrupt, format, length, status controls.
// - Bus framing, arbitration and acknowledge follow CAN 2.0B.
module cmc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CMC_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`CMC_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire cmc_pkg::cmc_frame_t rx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  output cmc_pkg::cmc_frame_t tx_frame,
  input wire logic link_error,
  output logic [31:0] bit_timing
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [31:0] mem [0:`CMC_MEM_WORDS-1];
  cmc_pkg::cmc_center_t ctr [0:`CMC_CENTERS-1];
  cmc_pkg::cmc_state_t state;
  logic ctrl_en;
  logic arb_chk;
  logic err_flag;
  logic [3:0] last_center;
  logic [`CMC_ID_W-1:0] id_mask;
  logic [15:0] data_mask;
  logic [7:0] arb0;
  logic [7:0] arb1;
  logic [5:0] dp_ptr;
  logic tx_reply;
  logic [3:0] tx_ctr;

  function automatic logic [3:0] lowest(input logic [14:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 14; k >= 0; k--) begin
      if (v[k]) r = 4'(k);
    end
    return r;
  endfunction

  function automatic logic [31:0] pack_ctr(input cmc_pkg::cmc_center_t c);
    return {15'h0000, c.rx_new, 4'h0, c.dlc, c.auto_reply, c.masked,
            c.int_en, c.transmit_request, c.center_ready, c.data_updated,
            c.transmit_inhibit, c.dir};
  endfunction

  // ------------------------------------------------------------
  // Frame FIFO on the receive path
  // ------------------------------------------------------------
  cmc_pkg::cmc_frame_t fq;
  logic fq_valid;
  wire fq_ready = (state == cmc_pkg::cmc_s_idle);

  cmc_fifo #(
    .WIDTH($bits(cmc_pkg::cmc_frame_t)),
    .DEPTH(`CMC_FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_frame),
    .out_valid(fq_valid),
    .out_ready(fq_ready),
    .out_data(fq)
  );

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  logic store_go;
  wire wr_take = awvalid && wvalid && !bvalid && !store_go;
  wire [7:0] wa = {awaddr[7:2], 2'b00};
  wire [7:0] wdiff = wa - `CMC_OFS_CENTER_FIRST;
  wire wr_is_ctr = (wa >= `CMC_OFS_CENTER_FIRST) &&
                   (wa <= `CMC_OFS_CENTER_LAST);
  wire [3:0] wr_ctr = wdiff[5:2];
  wire [31:0] wm = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}},
                    {8{wstrb[0]}}};
  wire wr_glob = (wa <= `CMC_OFS_DP_BUFFER);
  wire [31:0] wctrl = ({30'h0, arb_chk, ctrl_en} & ~wm) | (wdata & wm);
  wire [31:0] wtime = (bit_timing & ~wm) | (wdata & wm);
  wire [31:0] wmask = ({3'h0, id_mask} & ~wm) | (wdata & wm);
  wire [31:0] wdmask = ({16'h0000, data_mask} & ~wm) | (wdata & wm);
  wire [31:0] warb0 = ({24'h0, arb0} & ~wm) | (wdata & wm);
  wire [31:0] warb1 = ({24'h0, arb1} & ~wm) | (wdata & wm);
  wire [31:0] wptr = ({26'h0, dp_ptr} & ~wm) | (wdata & wm);
  wire ptr_ok = (dp_ptr < 6'(`CMC_MEM_WORDS));
  wire [31:0] buf_old = ptr_ok ? mem[dp_ptr] : 32'h0000_0000;
  wire buf_we = wr_take && (wa == `CMC_OFS_DP_BUFFER) && ptr_ok;
  wire err_clr = wr_take && (wa == `CMC_OFS_STATUS) &&
                 wdata[`CMC_STAT_ERR_BIT] && wstrb[0];
  assign awready = wr_take;
  assign wready = wr_take;

  // ------------------------------------------------------------
  // Acceptance, reply and transmit eligibility per center
  // ------------------------------------------------------------
  logic [14:0] rx_hit;
  logic [14:0] rem_hit;
  logic [14:0] tx_rdy;
  logic [14:0] new_vec;
  logic tx_done;
  // Standard frames compare only the low 11 identifier bits
  wire [`CMC_ID_W-1:0] fmt = fq.ide ? `CMC_EXT_ID_MASK : `CMC_STD_ID_MASK;
  wire [3:0] store_sel = lowest(rx_hit);
  wire [3:0] rem_sel = lowest(rem_hit);
  wire [3:0] sched_sel = lowest(tx_rdy);
  wire idle = (state == cmc_pkg::cmc_s_idle);
  assign store_go = idle && fq_valid && ctrl_en && !fq.rtr &&
                    (rx_hit != 15'h0000);
  wire rem_go = idle && fq_valid && ctrl_en && fq.rtr &&
                (rem_hit != 15'h0000);
  wire sched_go = idle && !fq_valid && ctrl_en && (tx_rdy != 15'h0000);

  genvar gi;
  generate
    for (gi = 0; gi < `CMC_CENTERS; gi++) begin : g_ctr
      localparam logic [5:0] BASE = 6'(gi * `CMC_WORDS_PER_CENTER);
      localparam bit RX_ONLY = (gi == `CMC_CENTERS - 1);
      wire [31:0] idw = mem[BASE];
      wire [`CMC_ID_W-1:0] idm = ctr[gi].masked ? id_mask : '0;
      wire [15:0] dm = ctr[gi].masked ? data_mask : '0;
      wire [`CMC_ID_W-1:0] diff = (fq.id ^ idw[`CMC_ID_W-1:0]) & fmt;
      wire fmt_ok = (idw[`CMC_IDW_IDE_BIT] == fq.ide);
      wire id_ok = fmt_ok && ((diff & ~idm) == '0);
      wire data_ok = !arb_chk ||
        ((fq.dlc >= 4'h2) &&
         (((fq.data[15:0] ^ {arb1, arb0}) & ~dm) == '0));
      wire [31:0] wv = (pack_ctr(ctr[gi]) & ~wm) | (wdata & wm);
      wire sw_we = wr_take && wr_is_ctr && (wr_ctr == 4'(gi));
      wire hw_store = store_go && (store_sel == 4'(gi));
      wire sent = tx_done && !tx_reply && (tx_ctr == 4'(gi));
      // The catch-all center takes any data frame, but only when no lower hits
      assign rx_hit[gi] = ctr[gi].center_ready && !ctr[gi].dir &&
                          (RX_ONLY || (id_ok && data_ok));
      assign rem_hit[gi] = ctr[gi].dir && ctr[gi].auto_reply && fmt_ok &&
                           (diff == '0);
      assign tx_rdy[gi] = ctr[gi].dir && !ctr[gi].transmit_inhibit &&
                          ctr[gi].data_updated && ctr[gi].center_ready &&
                          ctr[gi].transmit_request;
      assign new_vec[gi] = ctr[gi].rx_new;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctr[gi] <= '0;
        end else begin
          if (sent) ctr[gi].transmit_request <= 1'b0;
          if (sw_we) begin
            ctr[gi].dir <= RX_ONLY ? 1'b0 : wv[0];
            ctr[gi].transmit_inhibit <= wv[1];
            ctr[gi].data_updated <= wv[2];
            ctr[gi].center_ready <= wv[3];
            ctr[gi].transmit_request <= wv[4];
            ctr[gi].int_en <= wv[5];
            ctr[gi].masked <= wv[6];
            ctr[gi].auto_reply <= wv[7];
            ctr[gi].dlc <= wv[11:8];
            ctr[gi].rx_new <= ctr[gi].rx_new &
                              ~(wdata[`CMC_CC_RXNEW_BIT] & wstrb[2]);
          end
          // A frame landing in the clearing cycle keeps its flag
          if (hw_store) begin
            ctr[gi].rx_new <= 1'b1;
            ctr[gi].dlc <= fq.dlc;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Dual-port memory: engine stores, processor through pointer/buffer
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (store_go) begin
      mem[{store_sel, 2'b01}] <= fq.data[31:0];
      mem[{store_sel, 2'b10}] <= fq.data[63:32];
      if (store_sel == 4'(`CMC_CENTERS - 1)) begin
        mem[{store_sel, 2'b00}] <= {fq.ide, 2'b00, fq.id};
      end
    end
    // Bus writes are stalled while the engine stores, so no clash
    if (buf_we) mem[dp_ptr] <= (buf_old & ~wm) | (wdata & wm);
  end

  // ------------------------------------------------------------
  // Global registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en <= 1'b0;
      arb_chk <= 1'b0;
      err_flag <= 1'b0;
      last_center <= 4'h0;
      bit_timing <= `CMC_RST_BIT_TIMING;
      id_mask <= `CMC_RST_ID_MASK;
      data_mask <= `CMC_RST_DATA_MASK;
      arb0 <= `CMC_RST_ARB_BYTE;
      arb1 <= `CMC_RST_ARB_BYTE;
      dp_ptr <= 6'h00;
    end else begin
      if (wr_take) begin
        case (wa)
          `CMC_OFS_CTRL: begin
            ctrl_en <= wctrl[`CMC_CTRL_EN_BIT];
            arb_chk <= wctrl[`CMC_CTRL_ARB_BIT];
          end
          `CMC_OFS_BIT_TIMING: bit_timing <= wtime;
          `CMC_OFS_ID_MASK: id_mask <= wmask[`CMC_ID_W-1:0];
          `CMC_OFS_DATA_MASK: data_mask <= wdmask[15:0];
          `CMC_OFS_ARB_BYTE0: arb0 <= warb0[7:0];
          `CMC_OFS_ARB_BYTE1: arb1 <= warb1[7:0];
          `CMC_OFS_DP_POINTER: dp_ptr <= wptr[5:0];
          default: ;
        endcase
      end
      if (err_clr) err_flag <= 1'b0;
      if (link_error) err_flag <= 1'b1;
      if (store_go) last_center <= store_sel + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Transmit sequencer
  // ------------------------------------------------------------
  wire [3:0] tx_sel = rem_go ? rem_sel : sched_sel;
  wire [31:0] tx_idw = mem[{tx_sel, 2'b00}];
  assign tx_valid = (state == cmc_pkg::cmc_s_tx);
  assign tx_done = tx_valid && tx_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= cmc_pkg::cmc_s_idle;
      tx_frame <= '0;
      tx_reply <= 1'b0;
      tx_ctr <= 4'h0;
    end else begin
      case (state)
        cmc_pkg::cmc_s_idle: begin
          // Received frames beat scheduled sends; replies reuse the path
          if (rem_go || sched_go) begin
            state <= cmc_pkg::cmc_s_tx;
            tx_reply <= rem_go;
            tx_ctr <= tx_sel;
            tx_frame.ide <= tx_idw[`CMC_IDW_IDE_BIT];
            tx_frame.rtr <= 1'b0;
            tx_frame.id <= tx_idw[`CMC_ID_W-1:0];
            tx_frame.dlc <= ctr[tx_sel].dlc;
            tx_frame.data <= {mem[{tx_sel, 2'b10}], mem[{tx_sel, 2'b01}]};
          end
        end
        cmc_pkg::cmc_s_tx: begin
          // Frame held until the bit engine takes it
          if (tx_ready) state <= cmc_pkg::cmc_s_idle;
        end
        default: state <= cmc_pkg::cmc_s_idle;
      endcase
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite answers
  // ------------------------------------------------------------
  wire ar_take = arvalid && !rvalid;
  wire [7:0] ra = {araddr[7:2], 2'b00};
  wire [7:0] rdiff = ra - `CMC_OFS_CENTER_FIRST;
  wire rd_is_ctr = (ra >= `CMC_OFS_CENTER_FIRST) &&
                   (ra <= `CMC_OFS_CENTER_LAST);
  wire [3:0] rd_ctr = rdiff[5:2];
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  assign arready = ar_take;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `CMC_RESP_OKAY;
    if (rd_is_ctr) begin
      next_rdata = pack_ctr(ctr[rd_ctr]);
    end else begin
      case (ra)
        `CMC_OFS_CTRL: next_rdata = {30'h0, arb_chk, ctrl_en};
        `CMC_OFS_STATUS: next_rdata = {20'h0, last_center, 7'h0, err_flag};
        `CMC_OFS_NEW_DATA: next_rdata = {17'h0, new_vec};
        `CMC_OFS_BIT_TIMING: next_rdata = bit_timing;
        `CMC_OFS_ID_MASK: next_rdata = {3'h0, id_mask};
        `CMC_OFS_DATA_MASK: next_rdata = {16'h0000, data_mask};
        `CMC_OFS_ARB_BYTE0: next_rdata = {24'h0, arb0};
        `CMC_OFS_ARB_BYTE1: next_rdata = {24'h0, arb1};
        `CMC_OFS_DP_POINTER: next_rdata = {26'h0, dp_ptr};
        `CMC_OFS_DP_BUFFER: next_rdata = buf_old;
        default: next_rresp = `CMC_RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `CMC_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `CMC_RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp <= (wr_glob || wr_is_ctr) ? `CMC_RESP_OKAY : `CMC_RESP_DECERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= next_rresp;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  store_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    store_go |=> new_vec[$past(store_sel)] &&
    (last_center == $past(store_sel) + 4'h1))
    else $error("stored frame did not raise its flag");
  lowest_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    store_go |-> rx_hit[store_sel] &&
    ((rx_hit & ((15'h0001 << store_sel) - 15'h0001)) == 15'h0000))
    else $error("frame stored above a lower accepting center");
  c15_rx_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctr[`CMC_CENTERS-1].dir)
    else $error("last center turned to transmit");
  tx_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("transmit frame dropped before taken");
  reply_id_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rem_go |=> tx_valid && tx_reply && !tx_frame.rtr &&
    (tx_frame.id == $past(tx_idw[`CMC_ID_W-1:0])))
    else $error("remote frame not answered with stored contents");
  tx_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sched_go |=> tx_valid && (tx_ctr == $past(sched_sel)))
    else $error("ready center not sent");
  req_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_done && !tx_reply && !(wr_take && wr_is_ctr) |=>
    !ctr[$past(tx_ctr)].transmit_request)
    else $error("transmit request kept after send");
  buf_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    buf_we && (wstrb == 4'hF) |=>
    (mem[$past(dp_ptr)] == $past(wdata)))
    else $error("buffer write missed the pointed word");
  axi_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed before taken");
  axi_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_take |=> bvalid ##0 !awready)
    else $error("write answer missing");
endmodule

// file: sim/cmc_can_node.sv
// Behavioural model of the other nodes on the bus
`timescale 1ns/1ps
module cmc_can_node (
  input wire logic aclk,
  input wire logic rx_ready,
  input wire logic tx_valid,
  output logic rx_valid,
  output cmc_pkg::cmc_frame_t rx_frame,
  output logic tx_ready
);
  logic hold;
  initial begin
    hold = 1'b0;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    rx_frame = '1;
  end
  // Acknowledge slot: prompt or late at random, never while held
  always @(posedge aclk) begin
    tx_ready <= !hold && ($urandom % 3 != 0);
  end
  // Whole frames only; idle lines show the inverse of the last frame
  task automatic send(input cmc_pkg::cmc_frame_t f);
    rx_valid <= 1'b1;
    rx_frame <= f;
    do @(negedge aclk); while (!rx_ready);
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
    @(posedge aclk);
  endtask
endmodule

// file: sim/cmc_top_tb.sv
// Self-checking bench for the message center controller
`timescale 1ns/1ps
`include "cmc_cfg.svh"
module cmc_top_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_ready;
  logic tx_valid, tx_ready, link_error;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, bit_timing, d0;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  cmc_pkg::cmc_frame_t rx_frame, tx_frame, f;
  logic [33:0] exp_rd[$];
  logic [1:0] exp_b[$];
  cmc_pkg::cmc_frame_t exp_tx[$];
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  cmc_top dut_u (.awprot(3'h0), .arprot(3'h0), .*);
  cmc_can_node node_u (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  task automatic bad(input string m);
    num_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [33:0] e);
    n_compared++;
    if ({rresp, rdata} !== e) bad("read data or response");
  endtask
  task automatic cmp_tx();
    n_compared++;
    if (exp_tx.size() == 0) bad("unexpected frame sent");
    else if (tx_frame !== exp_tx.pop_front()) bad("sent frame");
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) bad("flag level");
  endtask
  task automatic cmp_b(input logic [1:0] e);
    n_compared++;
    if (bresp !== e) bad("write response");
  endtask
  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) bad("output word");
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) cmp_rd(exp_rd.pop_front());
    if (bvalid && bready) cmp_b(exp_b.pop_front());
    if (tx_valid && tx_ready) cmp_tx();
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Bus tasks; bready and rready stay high throughout
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = `CMC_RESP_OKAY, input logic [3:0] s = 4'hF);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge aclk); while (!(awready && wready));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r = `CMC_RESP_OKAY);
    exp_rd.push_back({r, e});
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
  endtask
  task automatic mw(input logic [5:0] p, input logic [31:0] d);
    wr(8'h20, {26'h0, p});
    wr(8'h24, d);
  endtask
  function automatic cmc_pkg::cmc_frame_t mk(input logic x, input logic r,
      input logic [28:0] id, input logic [63:0] d);
    mk = '{ide: x, rtr: r, id: id, dlc: 4'h8, data: d};
  endfunction
  // Offer a frame, then expect the storing center in the status word
  task automatic rx(input cmc_pkg::cmc_frame_t fr, input logic [3:0] c);
    node_u.send(fr);
    repeat (3) @(posedge aclk);
    rd(8'h04, {20'h0, c, 8'h00});
  endtask
  task automatic wait_tx();
    while (exp_tx.size() != 0) @(posedge aclk);
    @(posedge aclk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, arvalid, link_error} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, wstrb} = '0;
    void'($urandom(32'h02bf));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h0C, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'hFC, 32'h0, `CMC_RESP_DECERR);
    // Only the second byte lane is enabled
    d0 = $urandom;
    wr(8'h0C, d0, `CMC_RESP_OKAY, 4'h2);
    cmp_w(bit_timing, {16'h0, d0[15:8], 8'h00});
    rd(8'h0C, {16'h0, d0[15:8], 8'h00});
    wr(8'h80, 32'h1, `CMC_RESP_DECERR);
    wr(8'h00, 32'h3);
    wr(8'h18, 32'h5A);
    wr(8'h1C, 32'hA5);
    mw(6'h00, 32'h123);
    wr(8'h40, 32'h8);
    mw(6'h04, 32'h123);
    wr(8'h44, 32'h8);
    wr(8'h78, 32'h9);
    rd(8'h78, 32'h8);
    d0 = {16'($urandom), 16'hA55A};
    rx(mk(1'b0, 1'b0, 29'h123, {$urandom, d0}), 4'h1);
    wr(8'h20, 32'h1);
    rd(8'h24, d0);
    rx(mk(1'b0, 1'b0, 29'h123, {$urandom, d0 ^ 32'h1}), 4'hF);
    rx(mk(1'b1, 1'b0, 29'h123, {$urandom, d0}), 4'hF);
    rd(8'h08, 32'h4001);
    wr(8'h00, 32'h1);
    wr(8'h10, 32'hF);
    mw(6'h04, 32'h200);
    wr(8'h44, 32'h48);
    rx(mk(1'b0, 1'b0, 29'h20A, 64'h0), 4'h2);
    // Extended identifier held in center 3, sent on request
    f = mk(1'b1, 1'b0, 29'h1ABCDE1, {$urandom, $urandom});
    mw(6'h08, {1'b1, 2'b0, f.id});
    mw(6'h09, f.data[31:0]);
    mw(6'h0A, f.data[63:32]);
    exp_tx.push_back(f);
    wr(8'h48, 32'h81D);
    wait_tx();
    rd(8'h48, 32'h80D);
    // Inhibited center must stay silent; the monitor flags any frame
    wr(8'h48, 32'h81F);
    repeat (20) @(posedge aclk);
    rd(8'h48, 32'h81F);
    exp_tx.push_back(f);
    wr(8'h48, 32'h81D);
    wait_tx();
    wr(8'h48, 32'h885);
    exp_tx.push_back(f);
    node_u.send(mk(1'b1, 1'b1, f.id, 64'h0));
    wait_tx();
    // Stalled sender keeps the engine busy so the buffer fills
    node_u.hold = 1'b1;
    exp_tx.push_back(f);
    wr(8'h48, 32'h81D);
    do @(negedge aclk); while (!tx_valid);
    @(posedge aclk);
    for (int i = 0; i < 8; i++) node_u.send(mk(1'b0, 1'b0, 29'h7, 64'h0));
    @(negedge aclk);
    cmp_bit(rx_ready, 1'b0);
    @(posedge aclk);
    node_u.hold = 1'b0;
    wait_tx();
    repeat (12) @(negedge aclk);
    cmp_bit(rx_ready, 1'b1);
    @(posedge aclk);
    link_error <= 1'b1;
    @(posedge aclk);
    link_error <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(8'h04, 32'hF01);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'hF00);
    wr(8'h40, 32'h10008);
    rd(8'h08, 32'h4002);
    report_and_stop();
  end
endmodule
